//--- inc/eev_regs.svh
// Purpose: Offsets, field positions, reset values and vector offsets of the exception unit
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: Definitions only
`ifndef EEV_REGS_SVH
`define EEV_REGS_SVH

`define EEV_AW 12
`define EEV_NC 13
`define EEV_SRW 5

`define EEV_OFF_SR 12'h000
`define EEV_OFF_EPC 12'h004
`define EEV_OFF_ESR 12'h008
`define EEV_OFF_SAVED_FAULT_ADDRESS 12'h00c
`define EEV_OFF_VBR 12'h010
`define EEV_OFF_ISTS 12'h014
`define EEV_OFF_ICLR 12'h018
`define EEV_OFF_IEN 12'h01c
`define EEV_OFF_XBASE 12'h020
`define EEV_OFF_XCTL 12'h024
`define EEV_OFF_CAUSE 12'h028

`define EEV_SR_SM 0
`define EEV_SR_IEE 1
`define EEV_SR_DME 2
`define EEV_SR_IME 3
`define EEV_SR_HVS 4
`define EEV_SR_RST 5'h01

`define EEV_VEC_RESET 12'h100
`define EEV_VEC_BUSERR 12'h200
`define EEV_VEC_DPAGE 12'h300
`define EEV_VEC_IPAGE 12'h400
`define EEV_VEC_TICK 12'h500
`define EEV_VEC_ALIGN 12'h600
`define EEV_VEC_ILLEGAL 12'h700
`define EEV_VEC_EXT 12'h800
`define EEV_VEC_DTLB 12'h900
`define EEV_VEC_ITLB 12'ha00
`define EEV_VEC_RANGE 12'hb00
`define EEV_VEC_SYSCALL 12'hc00
`define EEV_VEC_TRAP 12'he00
`define EEV_HIGH_BASE 20'hf0000

`define EEV_PSZ_8K 2'h0
`define EEV_PSZ_16M 2'h1
`define EEV_PSZ_32G 2'h2
`define EEV_MASK_8K 32'h0000_1fff
`define EEV_MASK_16M 32'h00ff_ffff
`define EEV_MASK_32G 32'hffff_ffff

`endif

//--- inc/eev_pkg.sv
// Purpose: Types of the exception unit
// Assumes: Macros from eev_regs.svh
// Notes: Cause order is the taking priority, first is highest
`include "eev_regs.svh"
package eev_pkg;
    typedef enum logic [3:0] {
        EEV_C_RESET, EEV_C_BUSERR, EEV_C_ITLB, EEV_C_IPAGE, EEV_C_ILLEGAL,
        EEV_C_ALIGN, EEV_C_RANGE, EEV_C_DTLB, EEV_C_DPAGE, EEV_C_SYSCALL,
        EEV_C_TRAP, EEV_C_TICK, EEV_C_EXT
    } eev_cause_t;
    typedef struct packed {
        logic [`EEV_SRW-1:0] sr;
        logic [`EEV_SRW-1:0] saved_supervision_status;
        logic [31:0] epc;
        logic [31:0] saved_fault_address;
        logic [31:0] vbr;
        logic [`EEV_NC-1:0] pend;
        logic [`EEV_NC-1:0] ists;
        logic [`EEV_NC-1:0] ien;
        logic [3:0] cause;
        logic [31:0] xbase;
        logic [1:0] psz;
        logic redirect;
        logic [31:0] fetch_addr;
        logic [31:0] phys;
        logic phys_valid;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic ext_s1;
        logic ext_s2;
    } eev_state_t;
endpackage

//--- inc/eev_sel_if.sv
// Purpose: Carrier between the exception unit and its vector selector
// Assumes: Purely combinational selector
// Notes: None
`timescale 1ns/10ps
`default_nettype none
`include "eev_regs.svh"
interface eev_sel_if;
    logic [`EEV_NC-1:0] elig;
    logic hvs;
    logic [31:0] vbr;
    logic valid;
    eev_pkg::eev_cause_t cause;
    logic [31:0] vector;
    modport ctrl (output elig, output hvs, output vbr, input valid, input cause, input vector);
    modport sel (input elig, input hvs, input vbr, output valid, output cause, output vector);
endinterface
`default_nettype wire

//--- core/eev_vector_sel.sv
// Purpose: Pick one eligible exception and form its vector address
// Assumes: Eligible set already masked by the caller
// Notes: Combinational only
`timescale 1ns/10ps
`default_nettype none
`include "eev_regs.svh"
module eev_vector_sel #(
    parameter bit HAS_VBR = 1'b1
) (
    eev_sel_if.sel sel
);
    function automatic eev_pkg::eev_cause_t first_set(input logic [`EEV_NC-1:0] v);
        eev_pkg::eev_cause_t r;
        r = eev_pkg::EEV_C_RESET;
        for (int i = `EEV_NC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = eev_pkg::eev_cause_t'(i[3:0]);
            end
        end
        return r;
    endfunction

    function automatic logic [11:0] low_offset(input eev_pkg::eev_cause_t c);
        case (c)
            eev_pkg::EEV_C_RESET: return `EEV_VEC_RESET;
            eev_pkg::EEV_C_BUSERR: return `EEV_VEC_BUSERR;
            eev_pkg::EEV_C_DPAGE: return `EEV_VEC_DPAGE;
            eev_pkg::EEV_C_IPAGE: return `EEV_VEC_IPAGE;
            eev_pkg::EEV_C_TICK: return `EEV_VEC_TICK;
            eev_pkg::EEV_C_ALIGN: return `EEV_VEC_ALIGN;
            eev_pkg::EEV_C_ILLEGAL: return `EEV_VEC_ILLEGAL;
            eev_pkg::EEV_C_EXT: return `EEV_VEC_EXT;
            eev_pkg::EEV_C_DTLB: return `EEV_VEC_DTLB;
            eev_pkg::EEV_C_ITLB: return `EEV_VEC_ITLB;
            eev_pkg::EEV_C_RANGE: return `EEV_VEC_RANGE;
            eev_pkg::EEV_C_SYSCALL: return `EEV_VEC_SYSCALL;
            eev_pkg::EEV_C_TRAP: return `EEV_VEC_TRAP;
            default: return `EEV_VEC_RESET;
        endcase
    endfunction

    logic [19:0] hi;

    assign hi = (HAS_VBR ? sel.vbr[31:12] : 20'h00000) | (sel.hvs ? `EEV_HIGH_BASE : 20'h00000);
    assign sel.valid = |sel.elig;
    assign sel.cause = first_set(sel.elig);
    assign sel.vector = {hi, low_offset(sel.cause)};
endmodule
`default_nettype wire

//--- core/eev_exc_unit.sv
// Purpose: Exception entry, vectoring, mode control and page translation with APB registers
// Assumes: Event inputs are one-cycle pulses from core logic; external request is a pin level
// Notes: Synchronous faults are taken even while interrupt entry is disabled
//
// Behaviour
// - On entry save interrupted PC, status, and fault address where relevant.
// - On entry go supervisor, disable both translation units and interrupts.
// - Fetch resumes at per-cause vector; tick 0x500, align 0x600, illegal 0x700, range 0xB00.
// - Reset vectors to offset 0x100, bus error to 0x200.
// - Data page fault vectors to 0x300, instruction page fault to 0x400.
// - Taken external interrupt vectors to 0x800.
// - Data translation miss vectors to 0x900.
// - Instruction translation miss vectors to 0xA00.
// - Trap instruction or debug exception vectors to 0xE00.
// - Vector bits 31-12 come from high-vector select and vector base register.
// - Without base register and with high-vector select clear, upper bits are zero.
// - Exactly two privilege levels, user and supervisor.
// - With translation enabled every issued virtual address is translated.
// - Basic page size 8KB; 16MB and 32GB pages also offered.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "eev_regs.svh"
module eev_exc_unit #(
    parameter bit HAS_VBR = 1'b1
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`EEV_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output wire logic o_pready,
    output wire logic [31:0] o_prdata,
    output wire logic o_pslverr,
    input wire logic i_bus_error,
    input wire logic i_dpage_fault,
    input wire logic i_ipage_fault,
    input wire logic i_tick,
    input wire logic i_align,
    input wire logic i_illegal,
    input wire logic i_ext_irq,
    input wire logic i_dtlb_miss,
    input wire logic i_itlb_miss,
    input wire logic i_range,
    input wire logic i_syscall,
    input wire logic i_trap,
    input wire logic i_debug_exc,
    input wire logic [31:0] i_instr_pc,
    input wire logic [31:0] i_fault_addr,
    input wire logic i_rfe,
    input wire logic i_xlate_req,
    input wire logic i_xlate_instr,
    input wire logic [31:0] i_virt_addr,
    output wire logic o_redirect,
    output wire logic [31:0] o_fetch_addr,
    output wire logic o_supervisor,
    output wire logic o_dmmu_en,
    output wire logic o_immu_en,
    output wire logic [31:0] o_phys_addr,
    output wire logic o_phys_valid,
    output wire logic o_irq
);
    eev_pkg::eev_state_t st;
    eev_pkg::eev_state_t nxt;
    logic [`EEV_NC-1:0] new_evt;
    logic [`EEV_NC-1:0] int_mask;
    logic [`EEV_NC-1:0] take_hot;
    logic take;
    logic setup;
    logic access;
    logic xl_en;

    eev_sel_if sel_bus();

    eev_vector_sel #(
        .HAS_VBR(HAS_VBR)
    ) u_sel (
        .sel(sel_bus)
    );

    function automatic logic needs_ea(input eev_pkg::eev_cause_t c);
        case (c)
            eev_pkg::EEV_C_BUSERR,
            eev_pkg::EEV_C_DPAGE,
            eev_pkg::EEV_C_IPAGE,
            eev_pkg::EEV_C_ALIGN,
            eev_pkg::EEV_C_DTLB,
            eev_pkg::EEV_C_ITLB: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] page_mask(input logic [1:0] psz);
        case (psz)
            `EEV_PSZ_8K: return `EEV_MASK_8K;
            `EEV_PSZ_16M: return `EEV_MASK_16M;
            // A 32GB page spans the whole 32-bit space
            `EEV_PSZ_32G: return `EEV_MASK_32G;
            default: return `EEV_MASK_8K;
        endcase
    endfunction

    always_comb begin
        new_evt = '0;
        new_evt[eev_pkg::EEV_C_BUSERR] = i_bus_error;
        new_evt[eev_pkg::EEV_C_ITLB] = i_itlb_miss;
        new_evt[eev_pkg::EEV_C_IPAGE] = i_ipage_fault;
        new_evt[eev_pkg::EEV_C_ILLEGAL] = i_illegal;
        new_evt[eev_pkg::EEV_C_ALIGN] = i_align;
        new_evt[eev_pkg::EEV_C_RANGE] = i_range;
        new_evt[eev_pkg::EEV_C_DTLB] = i_dtlb_miss;
        new_evt[eev_pkg::EEV_C_DPAGE] = i_dpage_fault;
        new_evt[eev_pkg::EEV_C_SYSCALL] = i_syscall;
        new_evt[eev_pkg::EEV_C_TRAP] = i_trap | i_debug_exc;
        new_evt[eev_pkg::EEV_C_TICK] = i_tick;
    end

    // Interrupts wait while entry is disabled; faults cannot be deferred
    always_comb begin
        int_mask = '1;
        int_mask[eev_pkg::EEV_C_TICK] = st.sr[`EEV_SR_IEE];
        int_mask[eev_pkg::EEV_C_EXT] = st.sr[`EEV_SR_IEE];
    end

    assign sel_bus.elig = st.pend & int_mask;
    assign sel_bus.hvs = st.sr[`EEV_SR_HVS];
    assign sel_bus.vbr = st.vbr;
    assign take = sel_bus.valid;
    assign take_hot = take ? ({{(`EEV_NC-1){1'b0}}, 1'b1} << sel_bus.cause) : '0;
    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable & st.pready;
    assign xl_en = i_xlate_instr ? st.sr[`EEV_SR_IME] : st.sr[`EEV_SR_DME];

    always_comb begin
        nxt = st;
        nxt.redirect = 1'b0;
        nxt.phys_valid = 1'b0;
        nxt.pready = 1'b0;
        nxt.pslverr = 1'b0;
        nxt.ext_s1 = i_ext_irq;
        nxt.ext_s2 = st.ext_s1;
        // Taken bit clears, a new event in the same cycle keeps it pending
        nxt.pend = (st.pend & ~take_hot) | new_evt;
        // External request follows the line level, no stale entries
        nxt.pend[eev_pkg::EEV_C_EXT] = st.ext_s2;

        if (setup) begin
            nxt.pready = 1'b1;
            nxt.prdata = 32'h0000_0000;
            case (i_paddr)
                `EEV_OFF_SR: nxt.prdata = {{(32-`EEV_SRW){1'b0}}, st.sr};
                `EEV_OFF_EPC: nxt.prdata = st.epc;
                `EEV_OFF_ESR: nxt.prdata = {{(32-`EEV_SRW){1'b0}}, st.saved_supervision_status};
                `EEV_OFF_SAVED_FAULT_ADDRESS: nxt.prdata = st.saved_fault_address;
                `EEV_OFF_VBR: nxt.prdata = HAS_VBR ? st.vbr : 32'h0000_0000;
                `EEV_OFF_ISTS: nxt.prdata = {{(32-`EEV_NC){1'b0}}, st.ists};
                `EEV_OFF_ICLR: nxt.prdata = 32'h0000_0000;
                `EEV_OFF_IEN: nxt.prdata = {{(32-`EEV_NC){1'b0}}, st.ien};
                `EEV_OFF_XBASE: nxt.prdata = st.xbase;
                `EEV_OFF_XCTL: nxt.prdata = {30'h0000_0000, st.psz};
                `EEV_OFF_CAUSE: nxt.prdata = {28'h000_0000, st.cause};
                default: nxt.pslverr = 1'b1;
            endcase
        end

        if (access && i_pwrite) begin
            case (i_paddr)
                `EEV_OFF_SR: nxt.sr = i_pwdata[`EEV_SRW-1:0];
                `EEV_OFF_EPC: nxt.epc = i_pwdata;
                `EEV_OFF_ESR: nxt.saved_supervision_status = i_pwdata[`EEV_SRW-1:0];
                `EEV_OFF_SAVED_FAULT_ADDRESS: nxt.saved_fault_address = i_pwdata;
                `EEV_OFF_VBR: nxt.vbr = HAS_VBR ? i_pwdata : 32'h0000_0000;
                `EEV_OFF_ICLR: nxt.ists = st.ists & ~i_pwdata[`EEV_NC-1:0];
                `EEV_OFF_IEN: nxt.ien = i_pwdata[`EEV_NC-1:0];
                `EEV_OFF_XBASE: nxt.xbase = i_pwdata;
                `EEV_OFF_XCTL: nxt.psz = i_pwdata[1:0];
                default: nxt.sr = nxt.sr;
            endcase
        end

        // Entry overrides a same-cycle software write or return
        if (take) begin
            nxt.epc = i_instr_pc;
            nxt.saved_supervision_status = st.sr;
            if (needs_ea(sel_bus.cause)) begin
                nxt.saved_fault_address = i_fault_addr;
            end
            // Syscall reaches supervisor level here like every other cause
            nxt.sr[`EEV_SR_SM] = 1'b1;
            nxt.sr[`EEV_SR_IEE] = 1'b0;
            nxt.sr[`EEV_SR_DME] = 1'b0;
            nxt.sr[`EEV_SR_IME] = 1'b0;
            nxt.redirect = 1'b1;
            nxt.fetch_addr = sel_bus.vector;
            nxt.cause = sel_bus.cause;
        end else if (i_rfe) begin
            nxt.sr = st.saved_supervision_status;
        end

        // Event set wins over a clear in the same cycle
        nxt.ists = nxt.ists | take_hot;
        nxt.irq = |(nxt.ists & nxt.ien);

        if (i_xlate_req) begin
            nxt.phys_valid = 1'b1;
            if (xl_en) begin
                nxt.phys = (st.xbase & ~page_mask(st.psz)) | (i_virt_addr & page_mask(st.psz));
            end else begin
                nxt.phys = i_virt_addr;
            end
        end

        if (!i_reset_n) begin
            nxt = '0;
            nxt.sr = `EEV_SR_RST;
            nxt.pend[eev_pkg::EEV_C_RESET] = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        st <= nxt;
    end

    assign o_pready = st.pready;
    assign o_prdata = st.prdata;
    assign o_pslverr = st.pslverr;
    assign o_redirect = st.redirect;
    assign o_fetch_addr = st.fetch_addr;
    assign o_supervisor = st.sr[`EEV_SR_SM];
    assign o_dmmu_en = st.sr[`EEV_SR_DME];
    assign o_immu_en = st.sr[`EEV_SR_IME];
    assign o_phys_addr = st.phys;
    assign o_phys_valid = st.phys_valid;
    assign o_irq = st.irq;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);

    logic [19:0] exp_hi;
    assign exp_hi = (HAS_VBR ? st.vbr[31:12] : 20'h00000) |
                    (st.sr[`EEV_SR_HVS] ? `EEV_HIGH_BASE : 20'h00000);

    save_ctx_a: assert property (take |=> (st.epc == $past(i_instr_pc)) && (st.saved_supervision_status == $past(st.sr)))
        else $error("context not saved on entry");
    save_ea_a: assert property (take && needs_ea(sel_bus.cause) |=> st.saved_fault_address == $past(i_fault_addr))
        else $error("fault address not saved");
    entry_mode_a: assert property (take |=> o_supervisor && !o_dmmu_en && !o_immu_en && !st.sr[`EEV_SR_IEE])
        else $error("entry mode wrong");
    vec_low_a: assert property (take && sel_bus.cause == eev_pkg::EEV_C_TICK |=> o_redirect && o_fetch_addr[11:0] == 12'h500)
        else $error("tick vector wrong");
    vec_fault_a: assert property (take && sel_bus.cause == eev_pkg::EEV_C_BUSERR |=> o_fetch_addr[11:0] == 12'h200)
        else $error("bus error vector wrong");
    vec_reset_a: assert property ($rose(i_reset_n) |=> o_redirect && o_fetch_addr[11:0] == 12'h100)
        else $error("reset vector wrong");
    vec_page_a: assert property (take && sel_bus.cause == eev_pkg::EEV_C_DPAGE |=> o_fetch_addr[11:0] == 12'h300)
        else $error("data page vector wrong");
    vec_ext_a: assert property (take && sel_bus.cause == eev_pkg::EEV_C_EXT |=> o_fetch_addr[11:0] == 12'h800)
        else $error("external vector wrong");
    vec_tlb_a: assert property (take && sel_bus.cause == eev_pkg::EEV_C_DTLB |=> o_fetch_addr[11:0] == 12'h900)
        else $error("data miss vector wrong");
    vec_itlb_a: assert property (take && sel_bus.cause == eev_pkg::EEV_C_ITLB |=> o_fetch_addr[11:0] == 12'ha00)
        else $error("instruction miss vector wrong");
    vec_trap_a: assert property (take && sel_bus.cause == eev_pkg::EEV_C_TRAP |=> o_redirect && o_fetch_addr[11:0] == 12'he00)
        else $error("trap vector wrong");
    syscall_a: assert property (take && sel_bus.cause == eev_pkg::EEV_C_SYSCALL && !o_supervisor |=> o_supervisor && o_fetch_addr[11:0] == 12'hc00)
        else $error("system call entry wrong");
    vec_high_a: assert property (take |=> o_fetch_addr[31:12] == $past(exp_hi))
        else $error("vector upper bits wrong");
    one_taken_a: assert property (take |=> ((($past(sel_bus.elig) & ~$past(take_hot)) & ~st.pend) == '0) || $past(sel_bus.elig[eev_pkg::EEV_C_EXT]))
        else $error("lower priority cause lost");
    xlate_page_a: assert property (i_xlate_req && xl_en && st.psz == `EEV_PSZ_8K |=> o_phys_valid && o_phys_addr == {$past(st.xbase[31:13]), $past(i_virt_addr[12:0])})
        else $error("8KB translation wrong");
    apb_answer_a: assert property (setup |=> o_pready ##1 !o_pready)
        else $error("APB answer timing wrong");
endmodule
`default_nettype wire

//--- test/tb_eev_exc_unit.sv
// Purpose: Self-checking bench for the exception entry and vectoring unit
// Assumes: Zero-wait APB slave; events are one-cycle pulses, external request a level
// Notes: Bench drives every port itself; register offsets come from the shared header
`timescale 1ns/10ps
`default_nettype none
`include "eev_regs.svh"
module tb_eev_exc_unit;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, redirect, sup, dme, ime, pvalid, irq;
    logic [31:0] prdata, fetch, phys;
    logic [13:0] ev = 14'h0;
    logic [31:0] pc = 32'h0;
    logic [31:0] fa = 32'h0;
    logic rfe = 1'b0;
    logic xreq = 1'b0;
    logic xins = 1'b0;
    logic [31:0] va = 32'h0;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    // Index 13 is the debug exception, which shares the trap vector
    logic [11:0] vec_off [14] = '{12'h100, 12'h200, 12'ha00, 12'h400, 12'h700, 12'h600,
        12'hb00, 12'h900, 12'h300, 12'hc00, 12'he00, 12'h500, 12'h800, 12'he00};
    logic [13:0] ea_mask = 14'h01ae;

    eev_exc_unit dut (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_bus_error(ev[1]), .i_itlb_miss(ev[2]),
        .i_ipage_fault(ev[3]), .i_illegal(ev[4]), .i_align(ev[5]), .i_range(ev[6]),
        .i_dtlb_miss(ev[7]), .i_dpage_fault(ev[8]), .i_syscall(ev[9]), .i_trap(ev[10]),
        .i_tick(ev[11]), .i_ext_irq(ev[12]), .i_debug_exc(ev[13]), .i_instr_pc(pc),
        .i_fault_addr(fa), .i_rfe(rfe), .i_xlate_req(xreq), .i_xlate_instr(xins),
        .i_virt_addr(va), .o_redirect(redirect), .o_fetch_addr(fetch), .o_supervisor(sup),
        .o_dmmu_en(dme), .o_immu_en(ime), .o_phys_addr(phys), .o_phys_valid(pvalid),
        .o_irq(irq)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Returns in the time step of the access edge, so callers may drive by NBA next
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk_word(name, exp, rd);
    endtask

    task automatic fire(input logic [13:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= m & 14'h1000;
    endtask

    // External request is a level, so it is dropped only after entry is seen
    task automatic entry_chk(input logic [31:0] exp);
        @(negedge clk);
        while (redirect !== 1'b1) @(negedge clk);
        chk_word("fetch_addr", exp, fetch);
        chk_bit("supervisor", 1'b1, sup);
        chk_bit("dmmu_en", 1'b0, dme);
        chk_bit("immu_en", 1'b0, ime);
        @(posedge clk);
        ev <= 14'h0;
    endtask

    task automatic xlate(input logic side, input logic [31:0] exp);
        @(posedge clk);
        xreq <= 1'b1;
        xins <= side;
        va <= 32'h1234_5678;
        @(posedge clk);
        xreq <= 1'b0;
        @(negedge clk);
        chk_bit("phys_valid", 1'b1, pvalid);
        chk_word("phys_addr", exp, phys);
    endtask

    initial begin
        logic [31:0] rd;
        logic err;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        entry_chk(32'h0000_0100);
        rd_chk("sr", `EEV_OFF_SR, 32'h01);
        apb(1'b0, 12'h040, 32'h0, rd, err);
        chk_bit("slverr", 1'b1, err);
        apb(1'b0, 12'h006, 32'h0, rd, err);
        chk_bit("slverr", 1'b1, err);
        for (int k = 1; k < 14; k++) begin
            wr_reg(`EEV_OFF_SR, 32'h0e);
            pc <= 32'h4000_0000 | 32'(k << 4);
            fa <= 32'h0000_8000 | 32'(k);
            fire(14'h1 << k);
            entry_chk({20'h0, vec_off[k]});
            rd_chk("saved_status", `EEV_OFF_ESR, 32'h0e);
            rd_chk("saved_pc", `EEV_OFF_EPC, 32'h4000_0000 | 32'(k << 4));
            if (ea_mask[k]) begin
                rd_chk("saved_addr", `EEV_OFF_SAVED_FAULT_ADDRESS, 32'h0000_8000 | 32'(k));
            end
            rd_chk("cause", `EEV_OFF_CAUSE, (k == 13) ? 32'd10 : 32'(k));
            chk_bit("irq", 1'b0, irq);
        end
        wr_reg(`EEV_OFF_SR, 32'h0e);
        fire(14'h0030);
        entry_chk(32'h0000_0700);
        entry_chk(32'h0000_0600);
        wr_reg(`EEV_OFF_SR, 32'h0e);
        fire(14'h0200);
        entry_chk(32'h0000_0c00);
        @(posedge clk);
        rfe <= 1'b1;
        @(posedge clk);
        rfe <= 1'b0;
        @(negedge clk);
        chk_bit("supervisor", 1'b0, sup);
        wr_reg(`EEV_OFF_SR, 32'h0c);
        fire(14'h0800);
        repeat (6) begin
            @(negedge clk);
            chk_bit("redirect", 1'b0, redirect);
        end
        wr_reg(`EEV_OFF_SR, 32'h0e);
        entry_chk(32'h0000_0500);
        wr_reg(`EEV_OFF_VBR, 32'h1234_5000);
        wr_reg(`EEV_OFF_SR, 32'h1e);
        fire(14'h0040);
        entry_chk(32'hf234_5b00);
        wr_reg(`EEV_OFF_VBR, 32'h0);
        wr_reg(`EEV_OFF_XBASE, 32'h8765_4321);
        wr_reg(`EEV_OFF_SR, 32'h0c);
        for (int p = 0; p < 4; p++) begin
            wr_reg(`EEV_OFF_XCTL, 32'(p));
            for (int s = 0; s < 2; s++) begin
                xlate(s[0], (p == 1) ? 32'h8734_5678 :
                      (p == 2) ? 32'h1234_5678 : 32'h8765_5678);
            end
        end
        wr_reg(`EEV_OFF_SR, 32'h01);
        xlate(1'b0, 32'h1234_5678);
        xlate(1'b1, 32'h1234_5678);
        wr_reg(`EEV_OFF_ICLR, 32'h1fff);
        wr_reg(`EEV_OFF_IEN, 32'h20);
        wr_reg(`EEV_OFF_SR, 32'h0e);
        fire(14'h0020);
        entry_chk(32'h0000_0600);
        @(negedge clk);
        chk_bit("irq", 1'b1, irq);
        rd_chk("status", `EEV_OFF_ISTS, 32'h20);
        wr_reg(`EEV_OFF_ISTS, 32'h0);
        rd_chk("status", `EEV_OFF_ISTS, 32'h20);
        wr_reg(`EEV_OFF_ICLR, 32'h20);
        repeat (2) @(negedge clk);
        chk_bit("irq", 1'b0, irq);
        rd_chk("status", `EEV_OFF_ISTS, 32'h0);
        rd_chk("clear", `EEV_OFF_ICLR, 32'h0);
        wr_reg(`EEV_OFF_IEN, 32'h0);
        wr_reg(`EEV_OFF_SR, 32'h0e);
        fire(14'h0020);
        entry_chk(32'h0000_0600);
        repeat (2) @(negedge clk);
        chk_bit("irq", 1'b0, irq);
        rd_chk("status", `EEV_OFF_ISTS, 32'h20);
        // Second reset in mid-run must re-enter at the reset vector
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        entry_chk(32'h0000_0100);
        chk_bit("irq", 1'b0, irq);
        rd_chk("sr", `EEV_OFF_SR, 32'h01);
        tally_and_finish();
    end
endmodule
`default_nettype wire
